//--- fpp_pkg.sv
/*
  Constants of the fault propagation and PWM phase block.
  Assumes a 40 MHz core clock.
*/
package fpp_pkg;

  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned HICCUP_MS   = 130;
  localparam int unsigned HICCUP_CYCLES_DEF = CLK_FREQ_HZ / 1000 * HICCUP_MS;

  // Register offsets
  localparam logic [7:0] ADDR_INTERLEAVE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS      = 8'h16;
  localparam logic [7:0] ADDR_PROPAGATION = 8'h20;
  localparam logic [7:0] ADDR_LATCHING    = 8'h21;
  localparam logic [7:0] ADDR_STYLE       = 8'h22;

  // Reset values
  localparam logic [7:0] RST_INTERLEAVE  = 8'h00;
  localparam logic [7:0] RST_PROPAGATION = 8'h00;
  localparam logic [7:0] RST_LATCHING    = 8'h00;
  localparam logic [7:0] RST_STYLE       = 8'h08;

  // Interleave fields
  localparam int unsigned IL_LAG_LSB   = 0;
  localparam logic [7:0]  IL_WR_MASK   = 8'hef;
  localparam int unsigned IL_FREQ_BIT  = 5;
  localparam int unsigned IL_PCNT_LSB  = 6;

  // Fault vector index, shared by propagation, latching and qualification
  localparam int unsigned NFAULT = 5;
  localparam int unsigned F_TRK = 0;
  localparam int unsigned F_TMP = 1;
  localparam int unsigned F_CUR = 2;
  localparam int unsigned F_UND = 3;
  localparam int unsigned F_OVR = 4;

  // Status bits
  localparam int unsigned ST_OVR = 1;
  localparam int unsigned ST_UND = 2;
  localparam int unsigned ST_CUR = 3;
  localparam int unsigned ST_TMP = 4;
  localparam int unsigned ST_TRK = 5;
  localparam int unsigned ST_PGD = 6;
  localparam int unsigned ST_TWN = 7;

  // Style bits
  localparam int unsigned STY_TMP_CRIT = 0;
  localparam int unsigned STY_UND_CRIT = 1;
  localparam int unsigned STY_OVR_EMER = 2;
  localparam int unsigned STY_TRK_EN   = 3;

  typedef logic [1:0] fpp_off_t;
  localparam fpp_off_t OFF_SEQ  = 2'h0;
  localparam fpp_off_t OFF_CRIT = 2'h1;
  localparam fpp_off_t OFF_EMER = 2'h2;

  // Sixteenths of a sync period per phase offset and per half period
  localparam logic [3:0] STEP_PER_PHASE = 4'h4;
  localparam logic [3:0] STEP_HALF      = 4'h8;
  localparam int unsigned STEP_SHIFT    = 4;

endpackage

//--- fpp_top.sv
/*
  OK line fault propagation with severity coding, hiccup retry and PWM
  cycle starts locked to the manager sync line.
  Faults and qualifiers come from logic on clk_i; sync and OK are async
  pins; the OK wire level is resolved outside from ok_line_oe_n_o.
*/
// Overview of operation
// - Pull OK low when fault propagates
// - Peer OK low starts own matching turn-off
// - Encode turn-off type after OK falls
// - Non-propagating fault: release OK, stop alone
// - Propagation enables held in readable register
// - Non-latching fault retries every 130 ms
// - Undervoltage turn-off is sequenced by default
// - OK changes only at sync falling edge
// - Tracking only in ramp-up, critical, disableable
// - Overtemperature with power, sequenced or critical
// - Overcurrent above prebias, critical turn-off
// - Undervoltage in steady state, sequenced or critical
// - Overvoltage above prebias, low side on
// - Warnings set status only, never propagate
// - Cycle start locked to sync falling edge
// - Bit 5 selects 500 or 1000 kHz
// - Lag is field times 22.5 degrees
// - Phase count enables PWM outputs
// - Sequenced, critical, emergency turn-off types
`timescale 1ns/1ps

module fpp_top #(
  parameter int unsigned HICCUP_CYCLES = fpp_pkg::HICCUP_CYCLES_DEF,
  parameter int unsigned HIC_W         = 23,
  parameter int unsigned PER_W         = 10
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cfg_we_i,
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg_rdata_o,
  input  wire logic       tracking_fault_i,
  input  wire logic       overtemperature_fault_i,
  input  wire logic       overcurrent_fault_i,
  input  wire logic       undervoltage_fault_i,
  input  wire logic       overvoltage_error_i,
  input  wire logic       temperature_warning_i,
  input  wire logic       power_good_warning_i,
  input  wire logic       ramp_up_i,
  input  wire logic       steady_state_i,
  input  wire logic       above_prebias_i,
  input  wire logic       vin_present_i,
  input  wire logic       manager_sync_line_i,
  input  wire logic       ok_line_i,
  output logic            ok_line_o,
  output logic            ok_line_oe_n_o,
  output logic            shutdown_o,
  output logic      [1:0] shutdown_type_o,
  output logic            low_side_on_o,
  output logic            restart_o,
  output logic      [3:0] pwm_cycle_start_o,
  output logic      [3:0] pwm_phase_en_o,
  output logic            freq_1mhz_o
);

  typedef enum logic [1:0] {M_RUN = 2'b01, M_OFF = 2'b10} fpp_main_t;
  typedef enum logic [4:0] {T_IDLE = 5'b00001, T_S1 = 5'b00010, T_S2 = 5'b00100,
                            T_S3 = 5'b01000, T_HOLD = 5'b10000} fpp_tx_t;
  typedef enum logic [3:0] {R_IDLE = 4'b0001, R_A = 4'b0010, R_B = 4'b0100,
                            R_LOW = 4'b1000} fpp_rx_t;

  // Slot levels after the falling edge; 1 means the line is released
  function automatic logic [1:0] slots_of(input fpp_pkg::fpp_off_t t);
    case (t)
      fpp_pkg::OFF_CRIT: slots_of = 2'h1;
      fpp_pkg::OFF_EMER: slots_of = 2'h3;
      default:           slots_of = 2'h0;
    endcase
  endfunction

  function automatic fpp_pkg::fpp_off_t type_of(input logic a, input logic b);
    if (!a)
      type_of = fpp_pkg::OFF_SEQ;
    else if (b)
      type_of = fpp_pkg::OFF_EMER;
    else
      type_of = fpp_pkg::OFF_CRIT;
  endfunction

  // Synchronisers and edges
  logic sync_meta_ff, sync_ff, sync_prev_ff, ok_meta_ff, ok_ff;
  logic sync_fall, sync_rise;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_meta_ff <= 1'b1;
      sync_ff      <= 1'b1;
      sync_prev_ff <= 1'b1;
      ok_meta_ff   <= 1'b1;
      ok_ff        <= 1'b1;
    end
    else
    begin
      sync_meta_ff <= manager_sync_line_i;
      sync_ff      <= sync_meta_ff;
      sync_prev_ff <= sync_ff;
      ok_meta_ff   <= ok_line_i;
      ok_ff        <= ok_meta_ff;
    end
  end

  assign sync_fall = sync_prev_ff & ~sync_ff;
  assign sync_rise = ~sync_prev_ff & sync_ff;

  // Registers and fault qualification
  logic [7:0] inter_ff, prop_ff, latch_ff, style_ff, status_ff, rdata_ff;
  logic [7:0] nxt_inter, nxt_prop, nxt_latch, nxt_style, nxt_status, nxt_rdata;
  logic [fpp_pkg::NFAULT-1:0] fq;
  logic [fpp_pkg::NFAULT-1:0] fault_st;
  logic                       wr_status;

  always_comb
  begin
    fq = '0;
    fq[fpp_pkg::F_TRK] = tracking_fault_i & ramp_up_i & style_ff[fpp_pkg::STY_TRK_EN];
    fq[fpp_pkg::F_TMP] = overtemperature_fault_i & vin_present_i;
    fq[fpp_pkg::F_CUR] = overcurrent_fault_i & above_prebias_i;
    fq[fpp_pkg::F_UND] = undervoltage_fault_i & steady_state_i;
    fq[fpp_pkg::F_OVR] = overvoltage_error_i & above_prebias_i;
  end

  assign wr_status = cfg_we_i & (cfg_addr_i == fpp_pkg::ADDR_STATUS);
  assign fault_st  = {status_ff[fpp_pkg::ST_OVR], status_ff[fpp_pkg::ST_UND], status_ff[fpp_pkg::ST_CUR],
                      status_ff[fpp_pkg::ST_TMP], status_ff[fpp_pkg::ST_TRK]};

  always_comb
  begin
    nxt_inter = inter_ff;
    nxt_prop  = prop_ff;
    nxt_latch = latch_ff;
    nxt_style = style_ff;
    if (cfg_we_i)
    begin
      case (cfg_addr_i)
        fpp_pkg::ADDR_INTERLEAVE:  nxt_inter = cfg_wdata_i & fpp_pkg::IL_WR_MASK;
        fpp_pkg::ADDR_PROPAGATION: nxt_prop  = cfg_wdata_i;
        fpp_pkg::ADDR_LATCHING:    nxt_latch = cfg_wdata_i;
        fpp_pkg::ADDR_STYLE:       nxt_style = cfg_wdata_i;
        default:                   nxt_inter = inter_ff;
      endcase
    end
    // Set wins over a write-one clear in the same cycle; warnings only land here
    nxt_status = status_ff & ~(wr_status ? cfg_wdata_i : 8'h00);
    nxt_status[fpp_pkg::ST_TWN] = temperature_warning_i | nxt_status[fpp_pkg::ST_TWN];
    nxt_status[fpp_pkg::ST_PGD] = power_good_warning_i | nxt_status[fpp_pkg::ST_PGD];
    nxt_status[fpp_pkg::ST_TRK] = fq[fpp_pkg::F_TRK] | nxt_status[fpp_pkg::ST_TRK];
    nxt_status[fpp_pkg::ST_TMP] = fq[fpp_pkg::F_TMP] | nxt_status[fpp_pkg::ST_TMP];
    nxt_status[fpp_pkg::ST_CUR] = fq[fpp_pkg::F_CUR] | nxt_status[fpp_pkg::ST_CUR];
    nxt_status[fpp_pkg::ST_UND] = fq[fpp_pkg::F_UND] | nxt_status[fpp_pkg::ST_UND];
    nxt_status[fpp_pkg::ST_OVR] = fq[fpp_pkg::F_OVR] | nxt_status[fpp_pkg::ST_OVR];
    nxt_status[0] = 1'b0;
    case (cfg_addr_i)
      fpp_pkg::ADDR_INTERLEAVE:  nxt_rdata = inter_ff;
      fpp_pkg::ADDR_STATUS:      nxt_rdata = status_ff;
      fpp_pkg::ADDR_PROPAGATION: nxt_rdata = prop_ff;
      fpp_pkg::ADDR_LATCHING:    nxt_rdata = latch_ff;
      fpp_pkg::ADDR_STYLE:       nxt_rdata = style_ff;
      default:                   nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      inter_ff  <= fpp_pkg::RST_INTERLEAVE;
      prop_ff   <= fpp_pkg::RST_PROPAGATION;
      latch_ff  <= fpp_pkg::RST_LATCHING;
      style_ff  <= fpp_pkg::RST_STYLE;
      status_ff <= 8'h00;
      rdata_ff  <= 8'h00;
    end
    else
    begin
      inter_ff  <= nxt_inter;
      prop_ff   <= nxt_prop;
      latch_ff  <= nxt_latch;
      style_ff  <= nxt_style;
      status_ff <= nxt_status;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Turn-off control and hiccup retry
  fpp_main_t          state_ff, nxt_state;
  fpp_pkg::fpp_off_t  type_ff, nxt_type, worst;
  fpp_pkg::fpp_off_t  peer_type_ff, nxt_peer_type;
  logic [HIC_W-1:0]   hic_ff, nxt_hic;
  logic               drive_ff, nxt_drive, restart_ff, nxt_restart;
  logic               peer_trig_ff, nxt_peer_trig;

  always_comb
  begin
    if (fq[fpp_pkg::F_OVR] & style_ff[fpp_pkg::STY_OVR_EMER])
      worst = fpp_pkg::OFF_EMER;
    else if (fq[fpp_pkg::F_TRK] | fq[fpp_pkg::F_CUR] | fq[fpp_pkg::F_OVR] |
             (fq[fpp_pkg::F_TMP] & style_ff[fpp_pkg::STY_TMP_CRIT]) |
             (fq[fpp_pkg::F_UND] & style_ff[fpp_pkg::STY_UND_CRIT]))
      worst = fpp_pkg::OFF_CRIT;
    else
      worst = fpp_pkg::OFF_SEQ;
  end

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_type    = type_ff;
    nxt_hic     = hic_ff;
    nxt_drive   = drive_ff;
    nxt_restart = 1'b0;
    case (state_ff)
      M_RUN:
      begin
        if (|fq)
        begin
          nxt_state = M_OFF;
          nxt_type  = worst;
          nxt_hic   = '0;
          nxt_drive = |(fq & prop_ff[fpp_pkg::NFAULT-1:0]);
        end
        else if (peer_trig_ff)
        begin
          nxt_state = M_OFF;
          nxt_type  = peer_type_ff;
          nxt_hic   = '0;
          nxt_drive = 1'b0;
        end
      end
      M_OFF:
      begin
        // Hiccup timer runs from the fault, not from the end of the ramp-down
        if (hic_ff == HIC_W'(HICCUP_CYCLES - 1))
        begin
          nxt_hic = '0;
          if (!(|fq) && !(|(fault_st & latch_ff[fpp_pkg::NFAULT-1:0])) && (drive_ff || ok_ff))
          begin
            nxt_state   = M_RUN;
            nxt_drive   = 1'b0;
            nxt_restart = 1'b1;
          end
        end
        else
          nxt_hic = hic_ff + HIC_W'(1);
      end
      default: nxt_state = M_RUN;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff   <= M_RUN;
      type_ff    <= fpp_pkg::OFF_SEQ;
      hic_ff     <= '0;
      drive_ff   <= 1'b0;
      restart_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      type_ff    <= nxt_type;
      hic_ff     <= nxt_hic;
      drive_ff   <= nxt_drive;
      restart_ff <= nxt_restart;
    end
  end

  // OK line transmit: fall, then two coded slots, then held low
  fpp_tx_t    tx_ff, nxt_tx;
  logic [1:0] slot_ff, nxt_slot;
  logic       pull_ff, nxt_pull;

  always_comb
  begin
    nxt_tx   = tx_ff;
    nxt_slot = slot_ff;
    if (sync_fall)
    begin
      case (tx_ff)
        T_IDLE:
        begin
          if (drive_ff)
          begin
            nxt_tx   = T_S1;
            nxt_slot = slots_of(type_ff);
          end
        end
        T_S1:    nxt_tx = T_S2;
        T_S2:    nxt_tx = T_S3;
        T_S3:    nxt_tx = T_HOLD;
        T_HOLD:  nxt_tx = drive_ff ? T_HOLD : T_IDLE;
        default: nxt_tx = T_IDLE;
      endcase
    end
    nxt_pull = (nxt_tx == T_S1) | (nxt_tx == T_HOLD) |
               ((nxt_tx == T_S2) & ~nxt_slot[0]) | ((nxt_tx == T_S3) & ~nxt_slot[1]);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_ff   <= T_IDLE;
      slot_ff <= 2'h0;
      pull_ff <= 1'b0;
    end
    else
    begin
      tx_ff   <= nxt_tx;
      slot_ff <= nxt_slot;
      pull_ff <= nxt_pull;
    end
  end

  // OK line receive, sampled at sync rising edges mid-bit
  fpp_rx_t rx_ff, nxt_rx;
  logic    ok_prev_ff, nxt_ok_prev, bit_a_ff, nxt_bit_a;

  always_comb
  begin
    nxt_rx        = rx_ff;
    nxt_ok_prev   = ok_prev_ff;
    nxt_bit_a     = bit_a_ff;
    nxt_peer_trig = 1'b0;
    nxt_peer_type = peer_type_ff;
    if (sync_rise)
    begin
      nxt_ok_prev = ok_ff;
      case (rx_ff)
        R_IDLE:  nxt_rx = (ok_prev_ff & ~ok_ff) ? R_A : R_IDLE;
        R_A:
        begin
          nxt_bit_a = ok_ff;
          nxt_rx    = R_B;
        end
        R_B:
        begin
          nxt_peer_type = type_of(bit_a_ff, ok_ff);
          nxt_peer_trig = 1'b1;
          nxt_rx        = R_LOW;
        end
        R_LOW:   nxt_rx = ok_ff ? R_IDLE : R_LOW;
        default: nxt_rx = R_IDLE;
      endcase
      // Our own announcement is not taken as a peer's
      if (tx_ff != T_IDLE)
      begin
        nxt_rx        = R_LOW;
        nxt_peer_trig = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_ff        <= R_IDLE;
      ok_prev_ff   <= 1'b1;
      bit_a_ff     <= 1'b0;
      peer_trig_ff <= 1'b0;
      peer_type_ff <= fpp_pkg::OFF_SEQ;
    end
    else
    begin
      rx_ff        <= nxt_rx;
      ok_prev_ff   <= nxt_ok_prev;
      bit_a_ff     <= nxt_bit_a;
      peer_trig_ff <= nxt_peer_trig;
      peer_type_ff <= nxt_peer_type;
    end
  end

  // PWM phase: sync period measured and cut into sixteenths, 22.5 degrees each
  logic [PER_W-1:0] per_cnt_ff, nxt_per_cnt, period_ff, nxt_period, sub_ff, nxt_sub, sub_len;
  logic [3:0]       step_ff, nxt_step, pwm_ff, nxt_pwm, lag, phs_mask;
  logic             tick;

  assign sub_len = (period_ff >> fpp_pkg::STEP_SHIFT) == '0 ? PER_W'(1) : (period_ff >> fpp_pkg::STEP_SHIFT);
  assign lag     = inter_ff[fpp_pkg::IL_LAG_LSB +: 4];

  always_comb
  begin
    nxt_per_cnt = (&per_cnt_ff) ? per_cnt_ff : per_cnt_ff + PER_W'(1);
    nxt_period  = period_ff;
    nxt_sub     = sub_ff;
    nxt_step    = step_ff;
    tick        = 1'b0;
    if (sync_fall)
    begin
      nxt_period  = per_cnt_ff + PER_W'(1);
      nxt_per_cnt = '0;
      nxt_sub     = '0;
      nxt_step    = 4'h0;
      tick        = 1'b1;
    end
    else if (sub_ff == sub_len - PER_W'(1))
    begin
      nxt_sub = '0;
      if (step_ff != 4'hf)
      begin
        nxt_step = step_ff + 4'h1;
        tick     = 1'b1;
      end
    end
    else
      nxt_sub = sub_ff + PER_W'(1);
    case (inter_ff[fpp_pkg::IL_PCNT_LSB +: 2])
      2'h0:    phs_mask = 4'h1;
      2'h1:    phs_mask = 4'h5;
      2'h2:    phs_mask = 4'h7;
      default: phs_mask = 4'hf;
    endcase
  end

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_phase
      logic [3:0] tgt;
      assign tgt = lag + 4'(k) * fpp_pkg::STEP_PER_PHASE;
      assign nxt_pwm[k] = tick & phs_mask[k] & (state_ff == M_RUN) &
                          ((nxt_step == tgt) |
                           (inter_ff[fpp_pkg::IL_FREQ_BIT] & (nxt_step == tgt + fpp_pkg::STEP_HALF)));
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      per_cnt_ff <= '0;
      period_ff  <= '0;
      sub_ff     <= '0;
      step_ff    <= 4'hf;
      pwm_ff     <= 4'h0;
    end
    else
    begin
      per_cnt_ff <= nxt_per_cnt;
      period_ff  <= nxt_period;
      sub_ff     <= nxt_sub;
      step_ff    <= nxt_step;
      pwm_ff     <= nxt_pwm;
    end
  end

  assign cfg_rdata_o       = rdata_ff;
  assign ok_line_o         = 1'b0;
  assign ok_line_oe_n_o    = ~pull_ff;
  assign shutdown_o        = (state_ff == M_OFF);
  assign shutdown_type_o   = type_ff;
  assign low_side_on_o     = (state_ff == M_OFF) & (type_ff == fpp_pkg::OFF_EMER);
  assign restart_o         = restart_ff;
  assign pwm_cycle_start_o = pwm_ff;
  assign pwm_phase_en_o    = phs_mask & {4{state_ff == M_RUN}};
  assign freq_1mhz_o       = inter_ff[fpp_pkg::IL_FREQ_BIT];

endmodule // fpp_top

//--- fpp_properties.sv
/*
  Checker on the fpp_top ports.
  Assumes one clock domain; bound into every fpp_top.
*/
`timescale 1ns/1ps
module fpp_properties #(
  parameter int unsigned HICCUP_CYCLES = 200
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic       overcurrent_fault_i,
  input wire logic       overvoltage_error_i,
  input wire logic       undervoltage_fault_i,
  input wire logic       steady_state_i,
  input wire logic       above_prebias_i,
  input wire logic       manager_sync_line_i,
  input wire logic       ok_line_oe_n_o,
  input wire logic       shutdown_o,
  input wire logic [1:0] shutdown_type_o,
  input wire logic       low_side_on_o,
  input wire logic       restart_o,
  input wire logic [3:0] pwm_cycle_start_o,
  input wire logic [3:0] pwm_phase_en_o,
  input wire logic       freq_1mhz_o
);
  logic        sync_q_ff;
  logic        shut_q_ff;
  logic [3:0]  fall_age_ff;
  logic [31:0] off_cnt_ff;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // The sync pin is asynchronous, so its age is known only to within a cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_q_ff   <= 1'b1;
      shut_q_ff   <= 1'b0;
      fall_age_ff <= 4'hf;
      off_cnt_ff  <= 32'h0;
    end
    else
    begin
      sync_q_ff <= manager_sync_line_i;
      shut_q_ff <= shutdown_o;
      if (sync_q_ff && !manager_sync_line_i)
        fall_age_ff <= 4'h0;
      else if (fall_age_ff != 4'hf)
        fall_age_ff <= fall_age_ff + 4'h1;
      if (shutdown_o)
        off_cnt_ff <= shut_q_ff ? off_cnt_ff + 32'h1 : 32'h1;
    end
  end

  sequence s_oc_trip;
    !shutdown_o && overcurrent_fault_i && above_prebias_i && !overvoltage_error_i;
  endsequence
  sequence s_uv_trip;
    !shutdown_o && undervoltage_fault_i && steady_state_i;
  endsequence
  sequence s_off_held;
    shutdown_o ##1 shutdown_o;
  endsequence

  a_ok_sync_edge: assert property ($changed(ok_line_oe_n_o) |-> fall_age_ff inside {[1:5]})
    else $error("OK drive moved off a sync fall");
  a_oc_critical: assert property (s_oc_trip |=> shutdown_o && shutdown_type_o == fpp_pkg::OFF_CRIT)
    else $error("Overcurrent turn-off not critical");
  a_uv_turns_off: assert property (s_uv_trip |=> shutdown_o)
    else $error("Undervoltage did not turn off");
  a_low_side_emer: assert property (low_side_on_o == (shutdown_o && shutdown_type_o == fpp_pkg::OFF_EMER))
    else $error("Low side wrong for turn-off type");
  a_restart_pulse: assert property (restart_o |-> $past(shutdown_o) && !shutdown_o ##1 !restart_o)
    else $error("Restart pulse malformed");
  a_hiccup_len: assert property (restart_o |-> off_cnt_ff >= HICCUP_CYCLES - 1)
    else $error("Restart too early");
  a_off_masks_pwm: assert property (s_off_held |-> pwm_phase_en_o == 4'h0 && pwm_cycle_start_o == 4'h0)
    else $error("PWM active while turned off");
  a_freq_written: assert property (cfg_we_i && cfg_addr_i == fpp_pkg::ADDR_INTERLEAVE
    |=> freq_1mhz_o == $past(cfg_wdata_i[5]))
    else $error("Frequency select missed write");
  a_bit4_zero: assert property (cfg_addr_i == fpp_pkg::ADDR_INTERLEAVE |=> cfg_rdata_o[4] == 1'b0)
    else $error("Interleave bit 4 read as one");
  a_start_single: assert property (pwm_cycle_start_o[0] |=> !pwm_cycle_start_o[0])
    else $error("Cycle start wider than one clock");
endmodule // fpp_properties

bind fpp_top fpp_properties #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_props (.*);

//--- fpp_mgr_model.sv
/*
  Manager and peer model: sync line and a peer's coded OK pull-down.
  Assumes the bench pulls the OK wire up.
*/
`timescale 1ns/1ps
module fpp_mgr_model #(
  parameter int SYNC_NS = 2000
) (
  input  wire logic              peer_go_i,
  input  wire fpp_pkg::fpp_off_t peer_type_i,
  output logic                   sync_o,
  output logic                   peer_oe_n_o
);
  int unsigned slot = 0;

  // Odd offset keeps sync edges away from core clock edges
  initial
  begin
    sync_o      = 1'b1;
    peer_oe_n_o = 1'b1;
    #333;
    forever #(SYNC_NS / 2) sync_o = ~sync_o;
  end

  // Type is sent as given, never re-coded on the way
  always @(negedge sync_o)
  begin
    if (!peer_go_i)
    begin
      peer_oe_n_o <= 1'b1;
      slot        <= 0;
    end
    else
    begin
      slot <= slot + 1;
      case (slot)
        0: peer_oe_n_o <= 1'b0;
        1: peer_oe_n_o <= (peer_type_i != fpp_pkg::OFF_SEQ);
        2: peer_oe_n_o <= (peer_type_i == fpp_pkg::OFF_EMER);
        default: peer_oe_n_o <= 1'b0;
      endcase
    end
  end
endmodule // fpp_mgr_model

//--- fpp_tb_top.sv
/*
  Self-checking bench for fpp_top with the manager model.
  Assumes a 200-cycle retry interval and a pulled-up OK wire.
*/
`timescale 1ns/1ps
module fpp_tb_top;
  localparam int HIC = 200;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              we = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wd = 8'h00;
  logic [4:0]        flt = 5'h00;
  logic [3:0]        qual = 4'h0;
  logic [1:0]        warn = 2'h0;
  logic              peer_go = 1'b0;
  fpp_pkg::fpp_off_t peer_type = fpp_pkg::OFF_SEQ;
  logic [7:0]        rdata;
  logic [1:0]        stype;
  logic [3:0]        start;
  logic [3:0]        phase_en;
  logic              sync, peer_oe_n, oe_n, ok_wire, shut, low_side, restart, freq;
  int                error_cnt = 0;
  int                cmp_count = 0;

  assign ok_wire = oe_n & peer_oe_n;
  always #12.5 clk_i = ~clk_i;

  fpp_mgr_model u_mgr (.peer_go_i(peer_go), .peer_type_i(peer_type), .sync_o(sync), .peer_oe_n_o(peer_oe_n));

  // Qualifier bits: 0 ramp, 1 steady, 2 prebias, 3 input power
  fpp_top #(.HICCUP_CYCLES(HIC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
    .tracking_fault_i(flt[fpp_pkg::F_TRK]), .overtemperature_fault_i(flt[fpp_pkg::F_TMP]),
    .overcurrent_fault_i(flt[fpp_pkg::F_CUR]), .undervoltage_fault_i(flt[fpp_pkg::F_UND]),
    .overvoltage_error_i(flt[fpp_pkg::F_OVR]), .temperature_warning_i(warn[1]), .power_good_warning_i(warn[0]),
    .ramp_up_i(qual[0]), .steady_state_i(qual[1]), .above_prebias_i(qual[2]), .vin_present_i(qual[3]),
    .manager_sync_line_i(sync), .ok_line_i(ok_wire), .ok_line_o(), .ok_line_oe_n_o(oe_n),
    .shutdown_o(shut), .shutdown_type_o(stype), .low_side_on_o(low_side), .restart_o(restart),
    .pwm_cycle_start_o(start), .pwm_phase_en_o(phase_en), .freq_1mhz_o(freq)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    we = 1'b1;
    addr = a;
    wd = d;
    tick(1);
    we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
    tick(1);
    addr = a;
    tick(2);
    chk(n, e, rdata & m);
  endtask

  function automatic logic ev(input int s);
    case (s)
      0: return shut;
      1: return restart;
      2: return !oe_n;
      default: return oe_n;
    endcase
  endfunction

  task automatic wait_ev(input int s, input int lim, output int n);
    n = 0;
    while (ev(s) !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
      chk("event wait", 8'h01, 8'h00);
  endtask

  // The OK frame may still run after the restart, so its release can take three sync periods
  task automatic recover();
    int n;
    wait_ev(1, 3 * HIC, n);
    wait_ev(3, 400, n);
    wr(fpp_pkg::ADDR_STATUS, 8'hfe);
  endtask

  task automatic count_starts(input logic [7:0] cfg, output int c);
    wr(fpp_pkg::ADDR_INTERLEAVE, cfg);
    tick(200);
    c = 0;
    repeat (80)
    begin
      tick(1);
      c += $countones(start);
    end
  endtask

  task automatic t_regs();
    logic [3:0] pe [4] = '{4'h1, 4'h5, 4'h7, 4'hf};
    rd(fpp_pkg::ADDR_INTERLEAVE, 8'h00, 8'hff, "interleave reset");
    rd(fpp_pkg::ADDR_STYLE, 8'h08, 8'hff, "style reset");
    rd(8'h30, 8'h00, 8'hff, "unmapped");
    wr(fpp_pkg::ADDR_PROPAGATION, 8'h15);
    rd(fpp_pkg::ADDR_PROPAGATION, 8'h15, 8'hff, "propagation");
    wr(fpp_pkg::ADDR_INTERLEAVE, 8'hff);
    rd(fpp_pkg::ADDR_INTERLEAVE, 8'hef, 8'hff, "interleave");
    chk("freq", 8'h01, {7'h00, freq});
    for (int p = 0; p < 4; p++)
    begin
      wr(fpp_pkg::ADDR_INTERLEAVE, 8'(p << 6));
      tick(1);
      chk("phase enables", {4'h0, pe[p]}, {4'h0, phase_en});
    end
  endtask

  // Fault held past the first expiry, so the restart lands one interval later
  task automatic t_local();
    int n;
    int low = 0;
    wr(fpp_pkg::ADDR_PROPAGATION, 8'h00);
    qual = 4'h2;
    flt[fpp_pkg::F_UND] = 1'b1;
    wait_ev(0, 4, n);
    chk("undervolt type", 8'h00, {6'h00, stype});
    for (n = 0; n < 3 * HIC && restart !== 1'b1; n++)
    begin
      if (n == HIC + 40)
        flt[fpp_pkg::F_UND] = 1'b0;
      low += (oe_n !== 1'b1);
      tick(1);
    end
    chk("retry interval", 8'h01, 8'(n >= 2 * HIC - 2 && n <= 2 * HIC + 3));
    chk("ok released", 8'h00, 8'(low));
    rd(fpp_pkg::ADDR_STATUS, 8'h04, 8'h04, "undervolt status");
    wr(fpp_pkg::ADDR_STATUS, 8'hfe);
  endtask

  task automatic t_prop();
    int idx [3] = '{fpp_pkg::F_UND, fpp_pkg::F_CUR, fpp_pkg::F_OVR};
    logic [1:0] code [3] = '{2'h0, 2'h2, 2'h3};
    logic [1:0] s;
    int n;
    wr(fpp_pkg::ADDR_PROPAGATION, 8'h1f);
    wr(fpp_pkg::ADDR_STYLE, 8'h0c);
    qual = 4'h6;
    for (int t = 0; t < 3; t++)
    begin
      flt[idx[t]] = 1'b1;
      wait_ev(0, 4, n);
      chk("own type", 8'(t), {6'h00, stype});
      chk("low side", 8'(t == 2), {7'h00, low_side});
      wait_ev(2, 200, n);
      @(posedge sync);
      @(posedge sync);
      s[1] = ok_wire;
      @(posedge sync);
      s[0] = ok_wire;
      chk("severity code", {6'h00, code[t]}, {6'h00, s});
      flt[idx[t]] = 1'b0;
      recover();
    end
  endtask

  task automatic t_peer();
    int n;
    wr(fpp_pkg::ADDR_PROPAGATION, 8'h00);
    for (int t = 0; t < 3; t++)
    begin
      peer_type = fpp_pkg::fpp_off_t'(t);
      peer_go = 1'b1;
      wait_ev(0, 600, n);
      chk("peer type", 8'(t), {6'h00, stype});
      chk("own drive idle", 8'h01, {7'h00, oe_n});
      peer_go = 1'b0;
      wait_ev(1, 3 * HIC + 200, n);
    end
  endtask

  // Every fault present, only tracking qualified and that one disabled; warnings alone must not turn off
  task automatic t_quiet();
    int n;
    int bad = 0;
    wr(fpp_pkg::ADDR_STYLE, 8'h00);
    wr(fpp_pkg::ADDR_PROPAGATION, 8'h1f);
    qual = 4'h1;
    warn = 2'h3;
    flt = 5'h1f;
    repeat (300)
    begin
      tick(1);
      bad += (shut !== 1'b0 || oe_n !== 1'b1);
    end
    chk("unqualified off", 8'h00, 8'(bad));
    rd(fpp_pkg::ADDR_STATUS, 8'hc0, 8'hc0, "warning status");
    wr(fpp_pkg::ADDR_STYLE, 8'h08);
    wait_ev(0, 8, n);
    chk("tracking type", 8'h01, {6'h00, stype});
    flt = 5'h00;
    warn = 2'h0;
    recover();
  endtask

  task automatic t_pwm();
    int n;
    int c;
    count_starts(8'he2, c);
    chk("quad 1 MHz starts", 8'h08, 8'(c));
    @(negedge sync);
    for (n = 0; n < 60 && start[0] !== 1'b1; n++)
      tick(1);
    chk("lag delay", 8'h01, 8'(n >= 11 && n <= 16));
    count_starts(8'h00, c);
    chk("single 500 kHz starts", 8'h01, 8'(c));
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    tick(16);
    rst_i = 1'b0;
    t_regs();
    t_local();
    t_prop();
    t_peer();
    t_quiet();
    t_pwm();
    summarize();
  end

  initial
  begin
    #1_500_000;
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen timeout");
    summarize();
  end
endmodule // fpp_tb_top
